/* File: core/shp_port.sv */
// Host parallel port, mode straps, device reset and clock output enable
//
// Operation
// [R1] Clock enable low floats frame/bit clocks
// [R2] Host selects port by driving select low
// [R3] Deselected port idles, data bus floats
// [R4] Reset pin low resets; hold 1 ms
// [R5] Host resets after power-on, reference change
// [R6] Mode pin low: control from processor port
// [R7] Mode pin high: control from strap pins
// [R8] Eight-bit three-state data bus, bit0 LSB
// [R9] Direction high host reads, low writes
// [R10] Single address bit selects register
// [R11] Active-low data strobe times each transfer
// [R12] Write captured on strobe rising edge
`timescale 1ns/100ps
`default_nettype none
module shp_port #(
   parameter int RST_MIN_CYCLES = shp_pkg::RESET_MIN_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Host parallel port
   input  wire logic        host_port_select_n,
   input  wire logic        host_read_write,
   input  wire logic        register_address_bit,
   input  wire logic        host_data_strobe_n,
   input  wire logic [7:0]  host_data_bus_in,
   output logic [7:0]       host_data_bus_out,
   output logic             host_data_bus_oe,
   // Device reset pin and core reset
   input  wire logic        device_reset_n,
   output logic             core_reset_n,
   // Mode and strap pins
   input  wire logic        hardware_mode_select,
   input  wire logic        mode_strap_a,
   input  wire logic        mode_strap_b,
   input  wire logic        freq_strap_a,
   input  wire logic        freq_strap_b,
   input  wire logic        fast_acquire_pin,
   input  wire logic        network_standard_select,
   // Effective configuration
   output logic [1:0]       cfg_mode,
   output logic [1:0]       cfg_freq,
   output logic             cfg_fast_acquire,
   output logic             cfg_network_standard,
   // Clock outputs
   input  wire logic        clock_output_enable,
   input  wire logic [5:0]  gen_clocks,
   output logic             frame_pulse_16m,
   output logic             frame_pulse_8m,
   output logic             bit_clock_16m,
   output logic             bit_clock_8m,
   output logic             bit_clock_4m,
   output logic             bit_clock_2m,
   output logic             clock_outputs_oe
);
   localparam int CNT_W = $clog2(RST_MIN_CYCLES + 1);

   // Counter width grows with the minimum; refuse values it cannot serve
   if (RST_MIN_CYCLES < 1 || RST_MIN_CYCLES > 1000000) begin : g_bad_min
      $error("RST_MIN_CYCLES out of range");
   end

   logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
   logic             rst_short_ff, nxt_rst_short;
   logic             core_rst_n_ff, nxt_core_rst_n;
   logic [7:0]       ctrl_ff, nxt_ctrl;
   logic [7:0]       stat_ff, nxt_stat;
   logic [7:0]       wr_hold_ff, nxt_wr_hold;
   logic [7:0]       dout_ff, nxt_dout;
   logic             ds_prev_ff, nxt_ds_prev;
   logic             ack_ff, nxt_ack;
   logic [31:0]      rdata_ff, nxt_rdata;
   logic [5:0]       clk_q_ff, nxt_clk_q;
   logic [5:0]       cfg_bits;
   logic             selected, host_wr;
   logic             avs_req;

   // Core reset closes the port too, so no host write lands mid-reset
   assign selected = !host_port_select_n && core_rst_n_ff;   // [R2] [R3]
   // Write commits as the strobe rises while still selected
   assign host_wr  = selected && !host_read_write
                     && !ds_prev_ff && host_data_strobe_n;    // [R11] [R12]
   assign avs_req  = avs_read || avs_write;

   // Strap pins or host control byte steer the configuration
   always_comb begin
      if (hardware_mode_select) begin                       // [R7]
         cfg_bits = {network_standard_select, fast_acquire_pin,
                     freq_strap_b, freq_strap_a,
                     mode_strap_b, mode_strap_a};
      end else begin                                        // [R6]
         cfg_bits = ctrl_ff[5:0];
      end
   end
   // Field slices of the effective configuration
   assign cfg_mode             = cfg_bits[shp_pkg::CB_MODE_LSB +: 2];
   assign cfg_freq             = cfg_bits[shp_pkg::CB_FREQ_LSB +: 2];
   assign cfg_fast_acquire     = cfg_bits[shp_pkg::CB_FAST];
   assign cfg_network_standard = cfg_bits[shp_pkg::CB_NETSTD];

   // Reset pulse width tracking; the core stays in reset while pin is low
   always_comb begin
      nxt_rst_cnt    = rst_cnt_ff;
      nxt_rst_short  = rst_short_ff;
      nxt_core_rst_n = device_reset_n;                      // [R4]
      if (!device_reset_n) begin
         if (rst_cnt_ff != CNT_W'(RST_MIN_CYCLES))
            nxt_rst_cnt = rst_cnt_ff + CNT_W'(1);
      end else begin
         nxt_rst_cnt = '0;
         // Release after a pulse shorter than the minimum is flagged
         // A zero count means only the system reset held the core, which
         // is no short pin pulse and must not raise the flag
         if (!core_rst_n_ff && rst_cnt_ff != '0
             && rst_cnt_ff != CNT_W'(RST_MIN_CYCLES))
            nxt_rst_short = 1'b1;                           // [R4]
         else if (avs_write && ack_ff
                  && avs_address == shp_pkg::OFS_STATUS
                  && avs_writedata[shp_pkg::ST_RST_SHORT])
            nxt_rst_short = 1'b0;
      end
   end

   // Host and Avalon share the two port bytes; host write wins a collision
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_stat    = stat_ff;
      nxt_ds_prev = host_data_strobe_n;
      nxt_wr_hold = wr_hold_ff;
      // Byte latched every strobe-low cycle; the commit uses it one cycle on
      if (!host_data_strobe_n)
         nxt_wr_hold = host_data_bus_in;                    // [R8]
      if (avs_write && ack_ff && avs_address == shp_pkg::OFS_HOST_RD)
         nxt_stat = avs_writedata[7:0];
      if (host_wr) begin
         if (register_address_bit)                          // [R10]
            nxt_stat = wr_hold_ff;
         else
            nxt_ctrl = wr_hold_ff;
      end
      // Control byte held at its reset value while the core is in reset
      if (!core_rst_n_ff)
         nxt_ctrl = shp_pkg::HOST_REG_RST;                  // [R4]
      nxt_dout = register_address_bit ? stat_ff : ctrl_ff;  // [R10]
      nxt_clk_q = gen_clocks;
   end

   // Device drives the bus only on a selected read
   assign host_data_bus_out = dout_ff;
   assign host_data_bus_oe  = selected && host_read_write;  // [R3] [R9]

   // Clock outputs float while the enable pin is low
   assign clock_outputs_oe = clock_output_enable;           // [R1]
   assign frame_pulse_16m  = clk_q_ff[0];
   assign frame_pulse_8m   = clk_q_ff[1];
   assign bit_clock_16m    = clk_q_ff[2];
   assign bit_clock_8m     = clk_q_ff[3];
   assign bit_clock_4m     = clk_q_ff[4];
   assign bit_clock_2m     = clk_q_ff[5];
   assign core_reset_n     = core_rst_n_ff;

   // Avalon slave: one wait state, read data ready with the answer
   always_comb begin
      nxt_ack   = avs_req && !ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read && !ack_ff) begin
         nxt_rdata = shp_pkg::WORD_ZERO;  // Unmapped offsets read zero
         case (avs_address)
            shp_pkg::OFS_STATUS: begin
               nxt_rdata[shp_pkg::ST_HW_MODE]   = hardware_mode_select;
               nxt_rdata[shp_pkg::ST_CLK_OE]    = clock_output_enable;
               nxt_rdata[shp_pkg::ST_IN_RESET]  = !core_rst_n_ff;
               nxt_rdata[shp_pkg::ST_RST_SHORT] = rst_short_ff;
               nxt_rdata[shp_pkg::ST_CFG_LSB +: 6] = cfg_bits;
            end
            shp_pkg::OFS_HOST_RD: nxt_rdata[7:0] = stat_ff;
            shp_pkg::OFS_HOST_WR: nxt_rdata[7:0] = ctrl_ff;
            default:              nxt_rdata = shp_pkg::WORD_ZERO;
         endcase
      end
   end
   // A request held past its answer starts over, so the master must drop it
   assign avs_waitrequest = avs_req && !ack_ff;
   assign avs_readdata    = rdata_ff;

   // Register stage for all state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cnt_ff    <= '0;
         rst_short_ff  <= 1'b0;
         core_rst_n_ff <= 1'b0;
         ctrl_ff       <= shp_pkg::HOST_REG_RST;
         stat_ff       <= shp_pkg::HOST_REG_RST;
         wr_hold_ff    <= shp_pkg::HOST_REG_RST;
         dout_ff       <= shp_pkg::HOST_REG_RST;
         ds_prev_ff    <= 1'b1;
         ack_ff        <= 1'b0;
         rdata_ff      <= shp_pkg::WORD_ZERO;
         clk_q_ff      <= '0;
      end else begin
         rst_cnt_ff    <= nxt_rst_cnt;
         rst_short_ff  <= nxt_rst_short;
         core_rst_n_ff <= nxt_core_rst_n;
         ctrl_ff       <= nxt_ctrl;
         stat_ff       <= nxt_stat;
         wr_hold_ff    <= nxt_wr_hold;
         dout_ff       <= nxt_dout;
         ds_prev_ff    <= nxt_ds_prev;
         ack_ff        <= nxt_ack;
         rdata_ff      <= nxt_rdata;
         clk_q_ff      <= nxt_clk_q;
      end
   end
endmodule
`default_nettype wire

/* File: core/shp_pkg.sv */
// Constants shared by the host port and mode pin block
package shp_pkg;
   // Timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int RESET_MIN_NS    = 1000000;
   localparam int RESET_MIN_CYC   =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Avalon register byte offsets
   localparam logic [3:0] OFS_STATUS   = 4'h0;
   localparam logic [3:0] OFS_HOST_RD  = 4'h4;
   localparam logic [3:0] OFS_HOST_WR  = 4'h8;

   // Status register fields
   localparam int ST_HW_MODE    = 0;
   localparam int ST_CLK_OE     = 1;
   localparam int ST_IN_RESET   = 2;
   localparam int ST_RST_SHORT  = 3;
   localparam int ST_CFG_LSB    = 8;

   // Control byte fields (host register 0)
   localparam int CB_MODE_LSB   = 0;
   localparam int CB_FREQ_LSB   = 2;
   localparam int CB_FAST       = 4;
   localparam int CB_NETSTD     = 5;

   // Reset values
   localparam logic [7:0]  HOST_REG_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
endpackage

/* File: tb/shp_port_monitor.sv */
// Concurrent checks on the host port block pins
`timescale 1ns/100ps
`default_nettype none
module shp_port_monitor (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       host_port_select_n,
   input wire logic       host_read_write,
   input wire logic       register_address_bit,
   input wire logic       host_data_strobe_n,
   input wire logic [7:0] host_data_bus_in,
   input wire logic       host_data_bus_oe,
   input wire logic       device_reset_n,
   input wire logic       core_reset_n,
   input wire logic       hardware_mode_select,
   input wire logic       mode_strap_a,
   input wire logic [1:0] cfg_mode,
   input wire logic       clock_output_enable,
   input wire logic       clock_outputs_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Write committed while the port owns the configuration
   sequence s_wr;
      $rose(host_data_strobe_n) && !host_port_select_n && !host_read_write
         && core_reset_n && !hardware_mode_select;
   endsequence
   // Data is the bus of the last strobe-low cycle, two samples back
   property p_cap; s_wr ##0 !register_address_bit |=> hardware_mode_select
      || cfg_mode == $past(host_data_bus_in[1:0], 2); endproperty
   a_cap: assert property (p_cap) else $error("cap");
   property p_adr; s_wr ##0 register_address_bit |=> $stable(cfg_mode);
   endproperty
   a_adr: assert property (p_adr) else $error("adr");
   property p_clk; clock_outputs_oe == clock_output_enable; endproperty
   a_clk: assert property (p_clk) else $error("clk oe");
   property p_idle; host_port_select_n |-> !host_data_bus_oe; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_rd; !host_port_select_n && host_read_write && core_reset_n
      |-> host_data_bus_oe; endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_wr; !host_read_write |-> !host_data_bus_oe; endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_rst; !device_reset_n |=> !core_reset_n; endproperty
   a_rst: assert property (p_rst) else $error("rst");
   property p_hw; hardware_mode_select |-> cfg_mode[0] == mode_strap_a;
   endproperty
   a_hw: assert property (p_hw) else $error("hw");
   // The bus stays floating for as long as the core is held in reset
   property p_inrst; !core_reset_n |-> !host_data_bus_oe; endproperty
   a_inrst: assert property (p_inrst) else $error("inrst");
   c_wr: cover property (s_wr);
   c_rd: cover property (host_data_bus_oe);
   c_rst: cover property (!core_reset_n);
   c_coe: cover property (!clock_outputs_oe);
endmodule
bind shp_port shp_port_monitor u_mon (.*);
`default_nettype wire

/* File: tb/shp_host_model.sv */
// Behavioural eight-bit host processor on the parallel port
`timescale 1ns/100ps
`default_nettype none
module shp_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] host_data_bus_in,
   output logic            host_port_select_n,
   output logic            host_read_write,
   output logic            register_address_bit,
   output logic            host_data_strobe_n,
   output logic [7:0]      host_dq
);
   // Idle deselected at time zero
   initial begin
      host_port_select_n = 1'h1;
      host_read_write = 1'h1;
      register_address_bit = 1'h0;
      host_data_strobe_n = 1'h1;
      host_dq = 8'h00;
   end
   // Released bus shows the inverse byte so stale data never passes
   task automatic xfer(input logic r, input logic a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clk);
      host_port_select_n <= 1'h0;
      host_read_write <= r;
      register_address_bit <= a;
      host_dq <= d;
      host_data_strobe_n <= 1'h0;
      repeat (2) @(posedge clk);
      q = host_data_bus_in;
      host_data_strobe_n <= 1'h1;
      @(posedge clk);
      host_port_select_n <= 1'h1;
      host_read_write <= 1'h1;
      host_dq <= ~d;
   endtask
endmodule
`default_nettype wire

/* File: tb/test_shp_port.sv */
// Self-checking bench for the host port block
`timescale 1ns/100ps
`default_nettype none
module test_shp_port;
   typedef struct packed {logic h; logic [5:0] s, e; logic [7:0] b;}
      shp_row_type;
   logic        clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q32;
   logic [7:0]  host_data_bus_in, host_data_bus_out, host_dq, q8;
   logic [5:0]  straps = 6'h00, gen_clocks = 6'h00;
   logic [1:0]  cfg_mode, cfg_freq;
   logic        device_reset_n = 1'h0, hardware_mode_select = 1'h0;
   logic        clock_output_enable = 1'h1, avs_waitrequest, core_reset_n;
   logic        host_port_select_n, host_read_write, register_address_bit;
   logic        host_data_strobe_n, host_data_bus_oe, clock_outputs_oe;
   logic        mode_strap_a, mode_strap_b, freq_strap_a, freq_strap_b;
   logic        fast_acquire_pin, network_standard_select, cfg_fast_acquire;
   logic        cfg_network_standard, frame_pulse_16m, frame_pulse_8m;
   logic        bit_clock_16m, bit_clock_8m, bit_clock_4m, bit_clock_2m;
   int          n_fail = 0, samples_checked = 0;
   logic [5:0]  cfg_all, clk_all;
   // Mode, straps, expected cfg, control byte
   shp_row_type rows [4] = '{'{1'h0, 6'h3F, 6'h15, 8'h15},
      '{1'h1, 6'h2A, 6'h2A, 8'h3F}, '{1'h0, 6'h00, 6'h2A, 8'h2A},
      '{1'h1, 6'h15, 6'h15, 8'h2C}};
   assign {network_standard_select, fast_acquire_pin, freq_strap_b,
      freq_strap_a, mode_strap_b, mode_strap_a} = straps;
   // Data pins resolved from both drivers
   assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : host_dq;
   shp_port #(.RST_MIN_CYCLES(8)) u_dut (.*);
   shp_host_model u_host (.*);
   // Grouped outputs in strap and gen_clocks bit order, for one-line compares
   assign cfg_all = {cfg_network_standard, cfg_fast_acquire, cfg_freq,
      cfg_mode};
   assign clk_all = {bit_clock_2m, bit_clock_4m, bit_clock_8m, bit_clock_16m,
      frame_pulse_8m, frame_pulse_16m};
   always #25 clk = ~clk;
   task automatic chk(input string s, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s exp %h got %h", s, e, g);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Tests in order, then the verdict
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      // Power-on device reset held past the minimum pulse
      repeat (10) @(posedge clk);
      device_reset_n <= 1'h1;
      av(1'h0, 4'h0, 32'h0000_0000, q32);
      chk("por", 32'h0000_0002, q32);
      chk("coe on", 1'h1, clock_outputs_oe);
      $display("power-on done");
      foreach (rows[i]) begin
         hardware_mode_select <= rows[i].h;
         straps <= rows[i].s;
         u_host.xfer(1'h0, 1'h0, rows[i].b, q8);
         @(posedge clk);
         chk("cfg", rows[i].e, cfg_all);
      end
      $display("table done");
      hardware_mode_select <= 1'h0;
      u_host.xfer(1'h0, 1'h1, 8'h5A, q8);
      u_host.xfer(1'h1, 1'h1, 8'h00, q8);
      chk("rd5a", 8'h5A, q8);
      av(1'h1, 4'h4, 32'h0000_00C3, q32);
      u_host.xfer(1'h1, 1'h1, 8'h00, q8);
      chk("rd1", 8'hC3, q8);
      u_host.xfer(1'h1, 1'h0, 8'h00, q8);
      chk("rd0", 8'h2C, q8);
      @(posedge clk);
      chk("idle", 1'h0, host_data_bus_oe);
      av(1'h0, 4'h8, 32'h0000_0000, q32);
      chk("ctrl", 32'h0000_002C, q32);
      av(1'h0, 4'hC, 32'h0000_0000, q32);
      chk("unmapped", 32'h0000_0000, q32);
      $display("port done");
      device_reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      chk("core", 1'h0, core_reset_n);
      @(posedge clk);
      device_reset_n <= 1'h1;
      av(1'h0, 4'h0, 32'h0000_0000, q32);
      chk("short", 1'h1, q32[3]);
      av(1'h1, 4'h0, 32'h0000_0008, q32);
      av(1'h0, 4'h0, 32'h0000_0000, q32);
      chk("short clr", 32'h0000_0002, q32);
      av(1'h0, 4'h8, 32'h0000_0000, q32);
      chk("cleared", 32'h0000_0000, q32);
      $display("reset done");
      clock_output_enable <= 1'h0;
      gen_clocks <= 6'h2D;
      repeat (2) @(posedge clk);
      chk("coe", 1'h0, clock_outputs_oe);
      chk("clks", 6'h2D, clk_all);
      $display("clocks done");
      report_and_stop;
   end
   // Tests need about 80 cycles; cut a hang well beyond that
   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      report_and_stop;
   end
endmodule
`default_nettype wire
